/* File: npe_host.sv */
// Purpose: host controller driving a nibble port expander over its strobe bus
// Assumes: device pins synchronous to i_clk_sys; one transaction at a time
// Notes:   oe signals active low; bus and select lines fully timed here
`timescale 1ns/1ps
`default_nettype none
module npe_host #(
  parameter int unsigned NUM_DEV = 1
) (
  // clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset_n,
  // user request
  input  wire logic               i_req_valid,
  input  wire logic [$clog2(NUM_DEV+1)-1:0] i_req_dev,
  input  wire logic [1:0]         i_req_op,
  input  wire logic [1:0]         i_req_port,
  input  wire logic [3:0]         i_req_data,
  output logic                    o_req_ready,
  // user answer
  output logic                    o_rsp_valid,
  output logic [3:0]              o_rsp_data,
  // device pins
  output logic [NUM_DEV-1:0]      o_chip_select_n,
  output logic                    o_load_strobe_n,
  input  wire logic [3:0]         i_host_nibble_bus,
  output logic [3:0]              o_host_nibble_bus,
  output logic                    o_host_nibble_bus_oe_n
);
  // refuse select widths the one-hot decode cannot serve
  if (NUM_DEV < 1 || NUM_DEV > 16) begin : g_bad_num_dev
    $error("NUM_DEV must be 1..16");
  end

  typedef enum logic [7:0] {
    ST_IDLE  = 8'b0000_0001,
    ST_SEL   = 8'b0000_0010,
    ST_CMD   = 8'b0000_0100,
    ST_HOLD  = 8'b0000_1000,
    ST_LOW   = 8'b0001_0000,
    ST_HIGH  = 8'b0010_0000,
    ST_DESEL = 8'b0100_0000,
    ST_WAKE  = 8'b1000_0000
  } npe_state_e;

  npe_state_e               state_q;
  logic [1:0]               op_q;
  logic [1:0]               port_q;
  logic [3:0]               data_q;
  logic                     rd_q;
  logic [3:0]               rsp_data_q;
  logic                     rsp_valid_q;
  logic                     strobe_n_q;
  logic [3:0]               bus_q;
  logic                     bus_oe_n_q;
  logic [NUM_DEV-1:0]       cs_n_q;

  npe_tmr_if tmr_if ();

  npe_timer u_timer (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .tmr       (tmr_if)
  );

  function automatic logic [npe_pkg::CNT_W-1:0] cyc(input int unsigned n);
    cyc = (n < 1) ? 8'h01 : n[npe_pkg::CNT_W-1:0];
  endfunction

  // one-hot select for the addressed expander
  function automatic logic [NUM_DEV-1:0] dev_onehot(input logic [$clog2(NUM_DEV+1)-1:0] d);
    dev_onehot = '0;
    for (int i = 0; i < NUM_DEV; i++) begin
      if (d == i[$clog2(NUM_DEV+1)-1:0]) begin
        dev_onehot[i] = 1'b1;
      end
    end
  endfunction

  // phase timing: each state loads its minimum duration on entry
  always_comb begin
    tmr_if.start = 1'b0;
    tmr_if.load  = 8'h01;
    case (state_q)
      ST_IDLE: begin
        if (i_req_valid) begin
          tmr_if.start = 1'b1;
          tmr_if.load  = cyc(npe_pkg::CYC_CS);
        end
      end
      ST_WAKE: begin
        // keep select high for a setup time after the wake pulse
        tmr_if.start = 1'b1;
        tmr_if.load  = cyc(npe_pkg::CYC_CS);
      end
      ST_SEL: begin
        if (tmr_if.done) begin
          tmr_if.start = 1'b1;
          tmr_if.load  = cyc(npe_pkg::CYC_CMD_SU);
        end
      end
      ST_CMD: begin
        if (tmr_if.done) begin
          tmr_if.start = 1'b1;
          tmr_if.load  = cyc(npe_pkg::CYC_CMD_HD);
        end
      end
      ST_HOLD: begin
        if (tmr_if.done) begin
          // read and write both wait the longer of the device access time and the pulse width
          tmr_if.start = 1'b1;
          tmr_if.load  = cyc(((npe_pkg::CYC_LOW > npe_pkg::CYC_ACCESS) ? npe_pkg::CYC_LOW : npe_pkg::CYC_ACCESS)
                             - npe_pkg::CYC_CMD_HD);
        end
      end
      ST_LOW: begin
        if (tmr_if.done) begin
          tmr_if.start = 1'b1;
          tmr_if.load  = cyc(npe_pkg::CYC_DAT_HD);
        end
      end
      ST_HIGH: begin
        if (tmr_if.done) begin
          tmr_if.start = 1'b1;
          tmr_if.load  = cyc(npe_pkg::CYC_CS);
        end
      end
      ST_DESEL: begin
        tmr_if.start = 1'b0;
      end
      default: begin
        tmr_if.start = 1'b0;
      end
    endcase
  end

  // sequencer; a wake strobe after reset releases the device from its reset state
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state_q <= ST_WAKE;
    end else begin
      case (state_q)
        ST_WAKE:  state_q <= ST_DESEL;
        ST_IDLE:  state_q <= i_req_valid ? ST_SEL : ST_IDLE;
        ST_SEL:   state_q <= tmr_if.done ? ST_CMD : ST_SEL;
        ST_CMD:   state_q <= tmr_if.done ? ST_HOLD : ST_CMD;
        ST_HOLD:  state_q <= tmr_if.done ? ST_LOW : ST_HOLD;
        ST_LOW:   state_q <= tmr_if.done ? ST_HIGH : ST_LOW;
        ST_HIGH:  state_q <= tmr_if.done ? ST_DESEL : ST_HIGH;
        ST_DESEL: state_q <= tmr_if.done ? ST_IDLE : ST_DESEL;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  // request capture; one command then one data nibble per request
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      op_q   <= npe_pkg::OP_IN;
      port_q <= npe_pkg::PORT_A;
      data_q <= 4'h0;
      rd_q   <= 1'b0;
    end else if (state_q == ST_IDLE && i_req_valid) begin
      op_q   <= i_req_op;
      port_q <= i_req_port;
      data_q <= i_req_data;
      rd_q   <= (i_req_op == npe_pkg::OP_IN);
    end
  end

  // chip select held low across the whole transaction and its margins
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cs_n_q <= '1;
    end else if (state_q == ST_IDLE && i_req_valid) begin
      cs_n_q <= ~dev_onehot(i_req_dev);
    end else if (state_q == ST_DESEL && tmr_if.done) begin
      cs_n_q <= '1;
    end
  end

  // strobe: falls at end of command setup, rises after low time
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      strobe_n_q <= 1'b1;
    end else if (state_q == ST_WAKE) begin
      strobe_n_q <= 1'b0;
    end else if (state_q == ST_SEL && tmr_if.done) begin
      strobe_n_q <= 1'b1;
    end else if (state_q == ST_CMD && tmr_if.done) begin
      strobe_n_q <= 1'b0;
    end else if (state_q == ST_LOW && tmr_if.done) begin
      strobe_n_q <= 1'b1;
    end else if (state_q == ST_IDLE || state_q == ST_DESEL) begin
      strobe_n_q <= 1'b1;
    end
  end

  // bus drive: command nibble, then data for writes; released for reads
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      bus_q      <= 4'h0;
      bus_oe_n_q <= 1'b1;
    end else if (state_q == ST_SEL && tmr_if.done) begin
      bus_q      <= {op_q, port_q};
      bus_oe_n_q <= 1'b0;
    end else if (state_q == ST_HOLD && tmr_if.done) begin
      // write data must meet its setup long before the rising edge
      bus_q      <= rd_q ? 4'h0 : data_q;
      bus_oe_n_q <= rd_q;
    end else if (state_q == ST_HIGH && tmr_if.done) begin
      bus_oe_n_q <= 1'b1;
    end
  end

  // read data sampled just before the rising strobe edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rsp_data_q  <= 4'h0;
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (state_q == ST_LOW && tmr_if.done && rd_q) begin
        rsp_data_q  <= i_host_nibble_bus;
        rsp_valid_q <= 1'b1;
      end
    end
  end

  // outputs straight from flip-flops
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      o_req_ready <= 1'b0;
    end else begin
      // no ready straight after wake: a take there would drop select as the wake strobe rises
      o_req_ready <= (state_q == ST_DESEL && tmr_if.done) || (state_q == ST_IDLE && !i_req_valid);
    end
  end

  assign o_rsp_valid            = rsp_valid_q;
  assign o_rsp_data             = rsp_data_q;
  assign o_chip_select_n        = cs_n_q;
  assign o_load_strobe_n        = strobe_n_q;
  assign o_host_nibble_bus      = bus_q;
  assign o_host_nibble_bus_oe_n = bus_oe_n_q;
endmodule
`default_nettype wire

/* File: npe_pkg.sv */
// Purpose: shared constants for the nibble port expander host controller
// Assumes: 50 MHz system clock
// Notes:   timing counts derived from nanosecond figures, rounded up
package npe_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned T_CS_SETUP_NS   = 50;   // select setup/hold
  localparam int unsigned T_CMD_SETUP_NS  = 100;  // command setup before falling strobe
  localparam int unsigned T_CMD_HOLD_NS   = 60;   // command hold after falling strobe
  localparam int unsigned T_STROBE_LOW_NS = 700;  // least strobe low time
  localparam int unsigned T_RD_ACCESS_NS  = 650;  // device read data valid delay
  localparam int unsigned T_DAT_SETUP_NS  = 200;  // write data setup before rising strobe
  localparam int unsigned T_DAT_HOLD_NS   = 150;  // covers write hold and device read float
  localparam int unsigned CYC_CS     = (T_CS_SETUP_NS   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_CMD_SU = (T_CMD_SETUP_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_CMD_HD = (T_CMD_HOLD_NS   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_LOW    = (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_DAT_HD = (T_DAT_HOLD_NS   + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_ACCESS = (T_RD_ACCESS_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_DAT_SU = (T_DAT_SETUP_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // command nibble layout
  localparam int unsigned OP_MSB   = 3;
  localparam int unsigned OP_LSB   = 2;
  localparam int unsigned ADDR_MSB = 1;
  localparam int unsigned ADDR_LSB = 0;
  localparam logic [1:0] OP_IN  = 2'h0;
  localparam logic [1:0] OP_OUT = 2'h1;
  localparam logic [1:0] OP_OR  = 2'h2;
  localparam logic [1:0] OP_AND = 2'h3;
  localparam logic [1:0] PORT_A = 2'h0;
  localparam logic [1:0] PORT_B = 2'h1;
  localparam logic [1:0] PORT_C = 2'h2;
  localparam logic [1:0] PORT_D = 2'h3;
  localparam int unsigned CNT_W = 8;
endpackage

/* File: npe_tmr_if.sv */
// Purpose: carrier between sequencer and phase timer
// Assumes: single clock domain
// Notes:   start loads a count, done pulses when it expires
`timescale 1ns/1ps
`default_nettype none
interface npe_tmr_if;
  logic                       start;
  logic [npe_pkg::CNT_W-1:0]  load;
  logic                       done;
  modport seq (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface
`default_nettype wire

/* File: npe_timer.sv */
// Purpose: phase timer for strobe sequencing
// Assumes: load is at least one
// Notes:   done pulses load cycles after start
`timescale 1ns/1ps
`default_nettype none
module npe_timer (
  // clock and reset
  input  wire logic  i_clk_sys,
  input  wire logic  i_reset_n,
  // sequencer side
  npe_tmr_if.tmr     tmr
);
  logic [npe_pkg::CNT_W-1:0] cnt_q;
  logic                      done_q;
  // count down; a restart overrides a running phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (tmr.start) begin
      cnt_q  <= tmr.load;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 8'h01);
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
  assign tmr.done = done_q;
endmodule
`default_nettype wire

/* File: npe_host_properties.sv */
// Purpose: wire timing checks for the expander host
// Assumes: one expander on select bit 0
// Notes:   checks key on strobe edges while selected, or on the take, the read answer and the select rise
`timescale 1ns/1ps
`default_nettype none
module npe_host_properties #(
  parameter int unsigned NUM_DEV = 1
) (
  input wire logic               i_clk_sys,
  input wire logic               i_reset_n,
  input wire logic               i_req_valid,
  input wire logic [1:0]         i_req_op,
  input wire logic [1:0]         i_req_port,
  input wire logic [3:0]         i_req_data,
  input wire logic               o_req_ready,
  input wire logic               o_rsp_valid,
  input wire logic [NUM_DEV-1:0] o_chip_select_n,
  input wire logic               o_load_strobe_n,
  input wire logic [3:0]         o_host_nibble_bus,
  input wire logic               o_host_nibble_bus_oe_n
);
  logic [3:0] cmd_q;
  logic [3:0] dat_q;
  logic [7:0] low_q;
  wire        sel = !o_chip_select_n[0];
  wire        rd  = cmd_q[3:2] == npe_pkg::OP_IN;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // reference copy of the request, taken at the take edge
  always_ff @(posedge i_clk_sys) if (o_req_ready && i_req_valid) {cmd_q, dat_q} <= {i_req_op, i_req_port, i_req_data};
  // strobe low time; strobe is high in reset so this settles there
  always_ff @(posedge i_clk_sys) low_q <= o_load_strobe_n ? 8'h00 : low_q + 8'h01;
  property p_take;
    o_req_ready && i_req_valid |-> ##[4:16] ($fell(o_load_strobe_n) && sel);
  endproperty
  a_take: assert property (p_take) else $error("no strobe after take");
  property p_cmd;
    $fell(o_load_strobe_n) && sel |-> $past(sel, 3) && !o_host_nibble_bus_oe_n && o_host_nibble_bus == cmd_q
      && $past(o_host_nibble_bus, 4) == cmd_q;
  endproperty
  a_cmd: assert property (p_cmd) else $error("command nibble not set up");
  property p_cmd_hold;
    $fell(o_load_strobe_n) && sel |=> ($stable(o_host_nibble_bus) && !o_host_nibble_bus_oe_n) [*3];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command hold short");
  property p_wr;
    $rose(o_load_strobe_n) && sel && !rd |-> o_host_nibble_bus == dat_q && $past(o_host_nibble_bus, 9) == dat_q
      ##1 $stable(o_host_nibble_bus);
  endproperty
  a_wr: assert property (p_wr) else $error("write data wrong");
  property p_rd_float;
    $fell(o_load_strobe_n) && sel && rd |-> ##4 o_host_nibble_bus_oe_n [*8];
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("host drives during read");
  property p_rsp;
    o_rsp_valid |-> sel && rd ##1 !o_rsp_valid;
  endproperty
  a_rsp: assert property (p_rsp) else $error("bad read answer");
  property p_low;
    $rose(o_load_strobe_n) && sel |-> low_q >= 8'(npe_pkg::CYC_LOW);
  endproperty
  a_low: assert property (p_low) else $error("strobe low too short");
  property p_cs_hold;
    $rose(o_chip_select_n[0]) |-> $past(o_load_strobe_n, 3);
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("select hold short");
endmodule
bind npe_host npe_host_properties #(.NUM_DEV(NUM_DEV)) u_props (.i_clk_sys, .i_reset_n, .i_req_valid, .i_req_op,
  .i_req_port, .i_req_data, .o_req_ready, .o_rsp_valid, .o_chip_select_n, .o_load_strobe_n, .o_host_nibble_bus,
  .o_host_nibble_bus_oe_n);
`default_nettype wire

/* File: npe_dev_model.sv */
// Purpose: behavioural expander on the far side of the host
// Assumes: open-drain port lines, outside level given per line
// Notes:   reads answer only at the slowest access time
`timescale 1ns/1ps
`default_nettype none
module npe_dev_model (
  // host pins
  input  wire logic        i_cs_n,
  input  wire logic        i_strobe_n,
  input  wire logic [3:0]  i_bus,
  output logic [3:0]       o_bus,
  output var logic         o_bus_en = 1'b0,
  // port lines
  input  wire logic [15:0] i_ext,
  output logic [15:0]      o_port
);
  logic        rst_q = 1'b1;
  logic [3:0]  cmd_q;
  logic [3:0]  rel_q = 4'h0;
  logic [15:0] lat_q; // latches survive reset
  logic [3:0]  lv;
  // a released line pulls low on a stored 0 and lets go on a 1
  assign o_port = i_ext & ~({{4{rel_q[3]}}, {4{rel_q[2]}}, {4{rel_q[1]}}, {4{rel_q[0]}}} & ~lat_q);
  assign lv     = o_port[cmd_q[1:0]*4 +: 4];
  assign o_bus  = lv;
  // command capture; the first falling edge only ends power-on reset
  always @(negedge i_strobe_n) begin
    if (!i_cs_n && !rst_q) begin
      cmd_q = i_bus;
      if (cmd_q[3:2] == npe_pkg::OP_IN) o_bus_en <= #(npe_pkg::T_RD_ACCESS_NS) 1'b1;
    end
    rst_q = 1'b0;
  end
  // data nibble moves on the rising edge
  always @(posedge i_strobe_n) if (!i_cs_n && !rst_q) begin
    if (cmd_q[3:2] == npe_pkg::OP_IN) o_bus_en <= #(npe_pkg::T_DAT_HOLD_NS) 1'b0;
    else begin
      lat_q[cmd_q[1:0]*4 +: 4] = cmd_q[3:2] == npe_pkg::OP_OUT ? i_bus
                                 : cmd_q[2] ? i_bus & lv : i_bus | lv;
      rel_q[cmd_q[1:0]] = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: npe_host_tb.sv */
// Purpose: self-checking bench for the expander host
// Assumes: one expander, open-drain model on the far side
// Notes:   reference keeps latch and release state per port as ints
`timescale 1ns/1ps
`default_nettype none
module npe_host_tb;
  logic        i_clk_sys = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        valid     = 1'b0;
  logic [1:0]  op        = 2'h0;
  logic [1:0]  port      = 2'h0;
  logic [3:0]  data      = 4'h0;
  logic [15:0] ext       = 16'hffff;
  logic        ready, rsp_valid, strobe_n, oe_n, m_en;
  logic [0:0]  cs_n;
  logic [3:0]  rsp_data, h_bus, m_bus, bus;
  logic [15:0] pins;
  int          fail_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          rel[4] = '{0, 0, 0, 0};
  int          lat[4];
  // a released bus shows a changing pattern, never the last value
  assign bus = !oe_n ? h_bus : m_en ? m_bus : 4'(cyc);
  always #10 i_clk_sys = ~i_clk_sys;
  npe_host uut (.i_clk_sys, .i_reset_n, .i_req_valid(valid), .i_req_dev(1'b0), .i_req_op(op), .i_req_port(port),
    .i_req_data(data), .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .o_chip_select_n(cs_n),
    .o_load_strobe_n(strobe_n), .i_host_nibble_bus(bus), .o_host_nibble_bus(h_bus), .o_host_nibble_bus_oe_n(oe_n));
  npe_dev_model dev (.i_cs_n(cs_n[0]), .i_strobe_n(strobe_n), .i_bus(bus), .o_bus(m_bus), .o_bus_en(m_en),
    .i_ext(ext), .o_port(pins));
  task automatic chk(input string what, input int exp, input logic [15:0] got);
    check_count++;
    if (got !== 16'(exp)) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, 16'(exp), got);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // pin level of a port as the reference sees it
  function automatic int lvl(input int p);
    return rel[p] ? lat[p] & ext[p*4 +: 4] : ext[p*4 +: 4];
  endfunction
  // one request; valid is held until the take edge
  task automatic xfer(input logic [1:0] o, input logic [1:0] p, input logic [3:0] d, input logic [15:0] e);
    int r;
    @(posedge i_clk_sys);
    valid <= 1'b1;
    op    <= o;
    port  <= p;
    data  <= d;
    ext   <= e;
    do @(negedge i_clk_sys); while (ready !== 1'b1);
    @(posedge i_clk_sys);
    valid <= 1'b0;
    do @(negedge i_clk_sys); while (strobe_n !== 1'b0);
    r = lvl(p);
    if (o == npe_pkg::OP_IN) begin
      do @(negedge i_clk_sys); while (rsp_valid !== 1'b1);
      chk("read nibble", r, rsp_data);
    end else begin
      rel[p] = 1;
      lat[p] = o == npe_pkg::OP_OUT ? d : o == npe_pkg::OP_OR ? d | r : d & r;
    end
    do @(negedge i_clk_sys); while (ready !== 1'b1);
    chk("port lines", {4'(lvl(3)), 4'(lvl(2)), 4'(lvl(1)), 4'(lvl(0))}, pins);
  endtask
  // cycle ceiling, about three times the expected run
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count++;
      results();
    end
  end
  // host and model must never drive the bus together
  always @(negedge i_clk_sys) chk("bus contention", 0, {15'h0000, !oe_n && m_en});
  // reads of floating ports, every op on every port, then random traffic
  initial begin
    void'($urandom(53965));
    repeat (3) @(posedge i_clk_sys);
    chk("reset pins", 16'h000e, {cs_n, strobe_n, oe_n, ready});
    i_reset_n <= 1'b1;
    for (int i = 0; i < 48; i++) begin
      xfer(i < 4 ? 2'h0 : i < 20 ? 2'(i) : 2'($urandom), i < 4 ? 2'(i) : i < 20 ? 2'(i / 4) : 2'($urandom),
           4'($urandom), 16'($urandom));
    end
    // write ones, then the read returns the live outside level of those lines
    xfer(npe_pkg::OP_OUT, npe_pkg::PORT_C, 4'hf, 16'h5a5a);
    xfer(npe_pkg::OP_IN, npe_pkg::PORT_C, 4'h0, 16'h0c00);
    results();
  end
endmodule
`default_nettype wire
